// ### design/asr_pkg.sv
package asr_pkg;

    // Register bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register offsets, byte addresses on the plain register port
    localparam logic [11:0] ADDR_RX_DATA = 12'hf98;
    localparam logic [11:0] ADDR_TX_DATA = 12'hf99;
    localparam logic [11:0] ADDR_BAUD_LO = 12'hf9a;
    localparam logic [11:0] ADDR_BAUD_HI = 12'hf9b;
    localparam logic [11:0] ADDR_RX_STATUS_CTRL = 12'hf9c;
    localparam logic [11:0] ADDR_TX_STATUS_CTRL = 12'hf9d;
    localparam logic [11:0] ADDR_BAUD_CTRL = 12'hf9e;
    localparam logic [11:0] ADDR_INT_CONTROL = 12'hf9f;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'hfa0;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'hfa1;

    // Field positions in rx_status_ctrl
    localparam int RSC_SERIAL_PORT_ENABLE = 7;
    localparam int RSC_CONTINUOUS_RX_ENABLE = 4;
    localparam int RSC_FRAME_ERR = 2;
    localparam int RSC_OVERRUN = 1;

    // Field positions in baud_ctrl
    localparam int BCT_RX_IDLE = 6;

    // Field positions in int_control_reg
    localparam int ICR_RX_INT_ENABLE = 0;
    localparam int ICR_PERIPH_INT_ENABLE = 1;
    localparam int ICR_GLOBAL_INT_ENABLE = 2;

    // Sticky interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_RX_CHAR = 0;
    localparam int IRQ_OVERRUN = 1;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_BAUD = 16'h0000;
    localparam logic [1:0] RESET_IRQ = 2'h0;

    // Character format and receive timing
    localparam int CHAR_BITS = 8;
    localparam int OVERSAMPLE = 16;
    localparam int FIFO_DEPTH = 2;
    localparam int CLK_HZ = 50_000_000;

    // Receiver states
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA = 2'b10,
        ASR_STOP = 2'b11
    } asr_state_e;

    // One register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } asr_bus_req_s;

    // One FIFO entry: character and its own framing error
    typedef struct packed {
        logic frame_err;
        logic [7:0] data;
    } asr_entry_s;

endpackage : asr_pkg

// ### design/asr_receiver.sv
// Function
// - Low stop-bit sample marks framing error
// - Completed character enters FIFO, pending raised
// - Data read returns oldest entry, pops
// - No FIFO accepts while overrun stands
// - Pending equals enabled and FIFO nonempty
// - Receive request needs all three enables set
// - Framing bit stored per entry, head shown
// - Framing status read-only, never blocks reception
// - Port disable clears framing status; continuous not
// - Framing error alone raises no interrupt
// - All-errored FIFO keeps framing status set
// - Two entries; third character sets overrun
// - Overrun keeps stored entries, drops arrivals
// - Overrun clears only via enable clearing
//
// Chosen here: the strobed register port.
module asr_receiver #(
    parameter int unsigned OVERSAMPLE = asr_pkg::OVERSAMPLE,
    parameter int unsigned FIFO_DEPTH = asr_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire asr_pkg::asr_bus_req_s bus_i,
    output logic [7:0] rd_data_o,
    input wire logic rx_line_i,
    output logic rx_int_req_o,
    output logic irq_o
);

    // Elaboration-time limits of the logic
    if (OVERSAMPLE < 4 || OVERSAMPLE > 256)
    begin : g_bad_os
        $error("OVERSAMPLE must lie in 4..256");
    end
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16)
    begin : g_bad_depth
        $error("FIFO_DEPTH must lie in 2..16");
    end

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [7:0] OS_LAST = 8'(OVERSAMPLE - 1);
    localparam logic [7:0] OS_HALF = 8'(OVERSAMPLE / 2 - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
    localparam logic [2:0] BIT_LAST = 3'(asr_pkg::CHAR_BITS - 1);

    // Pointer advance with wrap for any depth
    function automatic logic [PTR_W-1:0] ptr_next(
        input logic [PTR_W-1:0] p
    );
        ptr_next = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    // Software-held control bytes, plus the hardware-set sticky event bits
    logic [7:0] rx_ctrl; // Control bits of rx_status_ctrl
    logic [7:0] tx_ctrl; // Stored only, transmitter lives elsewhere
    logic [7:0] tx_data; // Stored only
    logic [7:0] baud_ctrl; // Stored control bits
    logic [15:0] baud_divisor; // Oversample tick period minus one, in clocks
    logic [2:0] int_control_reg; // Three interrupt enables
    logic [1:0] irq_status; // Sticky event bits
    logic [1:0] irq_mask; // One enable per event

    // Enable decode
    logic serial_port_enable;
    logic continuous_rx_enable;
    logic rx_enabled;
    assign serial_port_enable = rx_ctrl[asr_pkg::RSC_SERIAL_PORT_ENABLE];
    assign continuous_rx_enable =
        rx_ctrl[asr_pkg::RSC_CONTINUOUS_RX_ENABLE];
    assign rx_enabled = serial_port_enable & continuous_rx_enable;

    // Bus decode; pending has no write path at all
    logic rd_rx_data;
    logic rd_irq_status;
    assign rd_rx_data = bus_i.rd && (bus_i.addr == asr_pkg::ADDR_RX_DATA);
    assign rd_irq_status = bus_i.rd &&
        (bus_i.addr == asr_pkg::ADDR_IRQ_STATUS);

    // Plain control registers written from the bus
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rx_ctrl <= asr_pkg::RESET_BYTE;
            tx_ctrl <= asr_pkg::RESET_BYTE;
            tx_data <= asr_pkg::RESET_BYTE;
            baud_ctrl <= asr_pkg::RESET_BYTE;
            baud_divisor <= asr_pkg::RESET_BAUD;
            int_control_reg <= '0;
            irq_mask <= asr_pkg::RESET_IRQ;
        end
        else if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                asr_pkg::ADDR_RX_STATUS_CTRL: rx_ctrl <= bus_i.wdata;
                asr_pkg::ADDR_TX_STATUS_CTRL: tx_ctrl <= bus_i.wdata;
                asr_pkg::ADDR_TX_DATA: tx_data <= bus_i.wdata;
                asr_pkg::ADDR_BAUD_CTRL: baud_ctrl <= bus_i.wdata;
                asr_pkg::ADDR_BAUD_LO: baud_divisor[7:0] <= bus_i.wdata;
                asr_pkg::ADDR_BAUD_HI: baud_divisor[15:8] <= bus_i.wdata;
                asr_pkg::ADDR_INT_CONTROL:
                    int_control_reg <= bus_i.wdata[2:0];
                asr_pkg::ADDR_IRQ_MASK: irq_mask <= bus_i.wdata[1:0];
                // Read-only and unmapped writes are dropped
                default: ;
            endcase
        end
    end

    // Three-stage pin synchroniser; only stage 1 reads stage 0
    logic [2:0] rx_sync;
    logic rx_level; // Filtered line level
    logic rx_level_prev; // Level one cycle ago, for edge detect
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rx_sync <= 3'h7;
            rx_level <= 1'b1;
            rx_level_prev <= 1'b1;
        end
        else
        begin
            rx_sync <= {rx_sync[1:0], rx_line_i};
            // Change accepted once stages 1 and 2 agree
            if (rx_sync[1] == rx_sync[2])
                rx_level <= rx_sync[2];
            rx_level_prev <= rx_level;
        end
    end

    // Receiver state
    asr_pkg::asr_state_e state;
    logic [15:0] brg_cnt; // Baud tick divider
    logic [7:0] os_cnt; // Ticks within current bit
    logic [2:0] bit_cnt; // Data bit index
    logic [7:0] rx_shift_reg; // Character being assembled
    logic char_done; // One-cycle pulse, character complete
    logic char_frame_err_flag; // Framing error of that character
    logic tick;
    logic start_edge;
    assign tick = (brg_cnt == 16'h0000);
    assign start_edge = rx_level_prev & ~rx_level;

    // Start detect, mid-bit sampling and stop check
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !rx_enabled)
        begin
            // Disabling aborts any character in flight
            state <= asr_pkg::ASR_IDLE;
            brg_cnt <= asr_pkg::RESET_BAUD;
            os_cnt <= 8'h00;
            bit_cnt <= 3'h0;
            rx_shift_reg <= asr_pkg::RESET_BYTE;
            char_done <= 1'b0;
            char_frame_err_flag <= 1'b0;
        end
        else
        begin
            char_done <= 1'b0;
            brg_cnt <= tick ? baud_divisor : brg_cnt - 16'h0001;
            unique case (state)
                asr_pkg::ASR_IDLE:
                begin
                    // Restart divider so the bit phase follows the edge
                    if (start_edge)
                    begin
                        state <= asr_pkg::ASR_START;
                        brg_cnt <= baud_divisor;
                        os_cnt <= 8'h00;
                    end
                end
                asr_pkg::ASR_START:
                begin
                    if (tick && os_cnt == OS_HALF)
                    begin
                        // Glitch shorter than half a bit is ignored
                        state <= rx_level ? asr_pkg::ASR_IDLE
                                          : asr_pkg::ASR_DATA;
                        os_cnt <= 8'h00;
                        bit_cnt <= 3'h0;
                    end
                    else if (tick)
                    begin
                        os_cnt <= os_cnt + 8'h01;
                    end
                end
                asr_pkg::ASR_DATA:
                begin
                    if (tick && os_cnt == OS_LAST)
                    begin
                        // Least significant bit first, mid-bit sample
                        rx_shift_reg <= {rx_level, rx_shift_reg[7:1]};
                        os_cnt <= 8'h00;
                        if (bit_cnt == BIT_LAST)
                        begin
                            state <= asr_pkg::ASR_STOP;
                        end
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    else if (tick)
                    begin
                        os_cnt <= os_cnt + 8'h01;
                    end
                end
                asr_pkg::ASR_STOP:
                begin
                    if (tick && os_cnt == OS_LAST)
                    begin
                        char_frame_err_flag <= ~rx_level;
                        char_done <= 1'b1;
                        os_cnt <= 8'h00;
                        state <= asr_pkg::ASR_IDLE;
                    end
                    else if (tick)
                    begin
                        os_cnt <= os_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    // Receive FIFO storage
    asr_pkg::asr_entry_s fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] head; // Oldest entry
    logic [PTR_W-1:0] tail; // Next free slot
    logic [CNT_W-1:0] count; // Entries held
    logic overrun_flag;
    logic pop;
    logic push;
    logic full_now;
    logic overrun_event;

    // A pop in the same cycle frees room for the arrival
    assign pop = rd_rx_data && (count != '0);
    assign full_now = (count == CNT_FULL) && !pop;
    assign push = char_done && !overrun_flag && !full_now;
    assign overrun_event = char_done && !overrun_flag && full_now;

    // FIFO pointers and count; port disable flushes everything
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !serial_port_enable)
        begin
            head <= '0;
            tail <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                tail <= ptr_next(tail);
            if (pop)
                head <= ptr_next(head);
            // Push and pop together leave the count alone
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

    // Entry contents, framing bit travels with its character
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            fifo_mem[tail] <= '{frame_err: char_frame_err_flag,
                                data: rx_shift_reg};
        end
    end

    // Overrun flag; only enable clearing removes it
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !rx_enabled)
        begin
            overrun_flag <= 1'b0;
        end
        else if (overrun_event)
        begin
            // Stored entries stay, the arrival is discarded
            overrun_flag <= 1'b1;
        end
    end

    // Head status; empty FIFO shows no framing error
    logic frame_err_flag;
    logic rx_pending_flag;
    logic [7:0] head_data;
    // Port disable hides the flag at once, before the flush lands
    assign frame_err_flag = serial_port_enable && (count != '0) &&
        fifo_mem[head].frame_err;
    assign head_data = fifo_mem[head].data;
    assign rx_pending_flag = rx_enabled && (count != '0);

    // Last character handed out, repeated on empty reads
    logic [7:0] last_rx;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            last_rx <= asr_pkg::RESET_BYTE;
        else if (pop)
            last_rx <= head_data;
    end

    // Sticky events; set beats a read-clear in the same cycle
    logic [1:0] irq_set;
    always_comb
    begin
        irq_set = '0;
        irq_set[asr_pkg::IRQ_RX_CHAR] = push;
        irq_set[asr_pkg::IRQ_OVERRUN] = overrun_event;
        // Framing error is deliberately not an event here
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            irq_status <= asr_pkg::RESET_IRQ;
        else if (rd_irq_status)
            irq_status <= irq_set; // New event survives the clear
        else
            irq_status <= irq_status | irq_set;
    end

    // Interrupt outputs, registered
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rx_int_req_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            // Pending itself ignores the interrupt enables; the request does not
            rx_int_req_o <= rx_pending_flag &&
                int_control_reg[asr_pkg::ICR_RX_INT_ENABLE] &&
                int_control_reg[asr_pkg::ICR_PERIPH_INT_ENABLE] &&
                int_control_reg[asr_pkg::ICR_GLOBAL_INT_ENABLE];
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // Read multiplexer, unmapped addresses read zero
    logic [7:0] next_rd_data;
    always_comb
    begin
        next_rd_data = 8'h00;
        unique case (bus_i.addr)
            asr_pkg::ADDR_RX_DATA:
                next_rd_data = pop ? head_data : last_rx;
            asr_pkg::ADDR_TX_DATA: next_rd_data = tx_data;
            asr_pkg::ADDR_BAUD_LO: next_rd_data = baud_divisor[7:0];
            asr_pkg::ADDR_BAUD_HI: next_rd_data = baud_divisor[15:8];
            asr_pkg::ADDR_RX_STATUS_CTRL:
            begin
                next_rd_data = rx_ctrl;
                // Status bits are hardware-owned, writes do not stick
                next_rd_data[asr_pkg::RSC_FRAME_ERR] =
                    frame_err_flag;
                // Enable clearing shows at once, flag drops a cycle later
                next_rd_data[asr_pkg::RSC_OVERRUN] =
                    overrun_flag && rx_enabled;
            end
            asr_pkg::ADDR_TX_STATUS_CTRL: next_rd_data = tx_ctrl;
            asr_pkg::ADDR_BAUD_CTRL:
            begin
                next_rd_data = baud_ctrl;
                next_rd_data[asr_pkg::BCT_RX_IDLE] =
                    (state == asr_pkg::ASR_IDLE);
            end
            asr_pkg::ADDR_INT_CONTROL:
                next_rd_data = {5'h00, int_control_reg};
            asr_pkg::ADDR_IRQ_STATUS:
                next_rd_data = {6'h00, irq_status};
            asr_pkg::ADDR_IRQ_MASK: next_rd_data = {6'h00, irq_mask};
            default: next_rd_data = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= bus_i.rd ? next_rd_data : 8'h00;
    end

endmodule // asr_receiver

// ### verif/asr_props.sv
module asr_props #(
    parameter int unsigned OVERSAMPLE = 16,
    parameter int unsigned FIFO_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire asr_pkg::asr_bus_req_s bus_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rx_line_i,
    input wire logic rx_int_req_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [7:0] rsc; // Shadow of the receive control byte
    logic [2:0] icr; // Shadow of the three interrupt enables
    logic [1:0] msk; // Shadow of the event mask
    logic rx_on; // Port and continuous receive both on
    logic [5:0] rsc_kept; // Control bits that read back as written
    assign rx_on = rsc[7] & rsc[4];
    assign rsc_kept = {rsc[7:3], rsc[0]};

    // Shadows follow software writes only
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rsc <= 8'h00;
            icr <= 3'h0;
            msk <= 2'h0;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == asr_pkg::ADDR_RX_STATUS_CTRL)
                rsc <= bus_i.wdata;
            if (bus_i.addr == asr_pkg::ADDR_INT_CONTROL)
                icr <= bus_i.wdata[2:0];
            if (bus_i.addr == asr_pkg::ADDR_IRQ_MASK)
                msk <= bus_i.wdata[1:0];
        end
    end

    // One read strobe at a given address
    sequence s_read(logic [11:0] a);
        bus_i.rd && bus_i.addr == a;
    endsequence

    chk_rd_idle_zero: assert property (!$past(bus_i.rd) |-> rd_data_o == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_unmapped_zero: assert property (s_read(12'hfa5) |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    chk_icr_readback: assert property (s_read(asr_pkg::ADDR_INT_CONTROL)
        |=> rd_data_o[2:0] == $past(icr))
        else $error("interrupt enables read back wrong");
    chk_int_needs_enables: assert property (
        rx_int_req_o |-> $past(icr) == 3'h7)
        else $error("receive request without all enables");
    chk_pend_needs_enable: assert property (
        rx_int_req_o |-> $past(rx_on))
        else $error("pending while receiver disabled");
    chk_disable_clears_err: assert property (
        s_read(asr_pkg::ADDR_RX_STATUS_CTRL) ##0 !rsc[7]
        |=> rd_data_o[2:1] == 2'b00)
        else $error("error bits set while port disabled");
    chk_continuous_rx_enable_clears_ovr: assert property (
        s_read(asr_pkg::ADDR_RX_STATUS_CTRL) ##0 !rsc[4] |=> !rd_data_o[1])
        else $error("overrun set while continuous receive off");
    chk_irq_needs_mask: assert property (irq_o |-> $past(msk) != 2'b00)
        else $error("interrupt with every event masked");
    chk_ctrl_readback: assert property (s_read(asr_pkg::ADDR_RX_STATUS_CTRL)
        |=> {rd_data_o[7:3], rd_data_o[0]} == $past(rsc_kept))
        else $error("control bits read back wrong");
endmodule // asr_props

bind asr_receiver asr_props #(
    .OVERSAMPLE(OVERSAMPLE),
    .FIFO_DEPTH(FIFO_DEPTH)
) u_props (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .bus_i(bus_i),
    .rd_data_o(rd_data_o),
    .rx_line_i(rx_line_i),
    .rx_int_req_o(rx_int_req_o),
    .irq_o(irq_o)
);

// ### verif/asr_line_model.sv
module asr_line_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bit length in clocks, the bench may change it between characters
    int bit_clks = BIT_CLKS;

    // Line rests high between characters
    initial line_o = 1'b1;

    // Hold one bit level for a whole bit time
    task automatic hold_bit(input logic b);
        line_o <= b;
        repeat (bit_clks) @(posedge clk_i);
    endtask

    // One character: start, eight bits low first, stop, idle gap
    task automatic send(input logic [7:0] d, input logic stop);
        hold_bit(1'b0);
        for (int i = 0; i < 8; i++)
            hold_bit(d[i]);
        hold_bit(stop); // Low here forces a bad stop bit
        hold_bit(1'b1); // Gap keeps the next start a clean fall
    endtask
endmodule // asr_line_model

// ### verif/tb_async_serial_receiver_fifo.sv
module tb_async_serial_receiver_fifo;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] RSC = asr_pkg::ADDR_RX_STATUS_CTRL;
    localparam logic [11:0] RXD = asr_pkg::ADDR_RX_DATA;
    localparam logic [11:0] ICR = asr_pkg::ADDR_INT_CONTROL;
    localparam logic [11:0] IST = asr_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] MSK = asr_pkg::ADDR_IRQ_MASK;

    logic clk_i; // 50 MHz system clock
    logic reset_n_i; // Synchronous, active low
    asr_pkg::asr_bus_req_s bus_i; // Register port request
    logic [7:0] rd_data_o; // Read data, one cycle after strobe
    logic rx_line; // Serial line from the far transmitter
    logic rx_int_req; // Gated receive request
    logic irq; // Masked event interrupt
    int fail_count;
    int checked;
    logic [7:0] rv;

    initial clk_i = 1'b0;
    always #10 clk_i = ~clk_i;

    asr_receiver #(.OVERSAMPLE(16), .FIFO_DEPTH(2)) dut (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .bus_i(bus_i),
        .rd_data_o(rd_data_o),
        .rx_line_i(rx_line),
        .rx_int_req_o(rx_int_req),
        .irq_o(irq)
    );

    // Divisor starts at 0, so a bit lasts 16 clocks
    asr_line_model #(.BIT_CLKS(16)) far_tx (
        .clk_i(clk_i),
        .line_o(rx_line)
    );

    // Compare one byte-wide result
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single-cycle write strobe
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask

    // Read strobe, data taken in the following cycle only
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [7:0] exp);
        @(posedge clk_i);
        bus_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1;
        rv = rd_data_o;
        chk(what, exp, rv);
    endtask

    // Lets the one-cycle flag lag settle
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic tx(input logic [7:0] d, input logic stop);
        @(posedge clk_i);
        far_tx.send(d, stop);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #1_000_000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        fail_count = 0;
        checked = 0;
        reset_n_i = 1'b0;
        bus_i = '0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd_chk("rx_status_ctrl", RSC, 8'h00);
        rd_chk("int_control", ICR, 8'h00);
        rd_chk("unmapped", 12'hfa5, 8'h00);
        rd_chk("rx_data", RXD, 8'h00);
        $display("test reset_values done");

        reg_wr(RSC, 8'h90);
        reg_wr(ICR, 8'h07);
        reg_wr(MSK, 8'h01);
        tx(8'ha5, 1'b1);
        settle();
        chk("rx_int_req", 8'h01, {7'h00, rx_int_req});
        chk("irq", 8'h01, {7'h00, irq});
        rd_chk("frame_err", RSC, 8'h90);
        rd_chk("rx_data", RXD, 8'ha5);
        settle();
        chk("rx_int_req", 8'h00, {7'h00, rx_int_req});
        rd_chk("irq_status", IST, 8'h01);
        rd_chk("irq_status", IST, 8'h00);
        $display("test basic_receive done");

        // Every enable combination against one held character
        reg_wr(MSK, 8'h00);
        tx(8'h3c, 1'b1);
        for (int v = 0; v < 8; v++)
        begin
            reg_wr(ICR, v[7:0]);
            settle();
            chk("rx_int_req", {7'h00, v == 7}, {7'h00, rx_int_req});
            chk("irq", 8'h00, {7'h00, irq});
        end
        rd_chk("rx_data", RXD, 8'h3c);
        rd_chk("irq_status", IST, 8'h01);
        $display("test enables done");

        reg_wr(MSK, 8'h03);
        tx(8'h5e, 1'b0);
        tx(8'h81, 1'b1);
        rd_chk("frame_err", RSC, 8'h94);
        rd_chk("rx_data", RXD, 8'h5e);
        rd_chk("frame_err", RSC, 8'h90);
        rd_chk("rx_data", RXD, 8'h81);
        rd_chk("irq_status", IST, 8'h01);
        tx(8'h11, 1'b0);
        tx(8'h22, 1'b0);
        rd_chk("frame_err", RSC, 8'h94);
        rd_chk("rx_data", RXD, 8'h11);
        rd_chk("frame_err", RSC, 8'h94);
        rd_chk("rx_data", RXD, 8'h22);
        rd_chk("rx_data", RXD, 8'h22);
        chk("rx_int_req", 8'h00, {7'h00, rx_int_req});
        $display("test framing done");

        tx(8'h66, 1'b0);
        reg_wr(RSC, 8'h80);
        rd_chk("frame_err", RSC, 8'h84);
        settle();
        chk("rx_int_req", 8'h00, {7'h00, rx_int_req});
        reg_wr(RSC, 8'h00);
        rd_chk("frame_err", RSC, 8'h00);
        reg_wr(RSC, 8'h90);
        settle();
        chk("rx_int_req", 8'h00, {7'h00, rx_int_req});
        rd_chk("irq_status", IST, 8'h01);
        $display("test port_disable done");

        tx(8'h01, 1'b1);
        tx(8'h02, 1'b1);
        tx(8'h03, 1'b1);
        rd_chk("overrun", RSC, 8'h92);
        tx(8'h04, 1'b1);
        rd_chk("rx_data", RXD, 8'h01);
        rd_chk("rx_data", RXD, 8'h02);
        settle();
        chk("rx_int_req", 8'h00, {7'h00, rx_int_req});
        rd_chk("irq_status", IST, 8'h03);
        rd_chk("overrun", RSC, 8'h92);
        reg_wr(RSC, 8'h80);
        rd_chk("overrun", RSC, 8'h80);
        reg_wr(RSC, 8'h90);
        tx(8'h07, 1'b1);
        rd_chk("rx_data", RXD, 8'h07);
        $display("test overrun done");

        // Divisor 1 makes each bit 32 clocks long
        reg_wr(asr_pkg::ADDR_BAUD_LO, 8'h01);
        rd_chk("baud_lo", asr_pkg::ADDR_BAUD_LO, 8'h01);
        far_tx.bit_clks = 32;
        tx(8'hc3, 1'b1);
        rd_chk("rx_idle", asr_pkg::ADDR_BAUD_CTRL, 8'h40);
        rd_chk("rx_data", RXD, 8'hc3);
        $display("test baud_divisor done");
        stop_test();
    end
endmodule // tb_async_serial_receiver_fifo
